// *** hdl/amp_diag_seq.sv ***
// Load diagnostic sequencer, output state ramp and clip/warning pin control
// Operation
// R1 - Diagnostic start forces tested channels Hi-Z
// R2 - Pop-free ramp completes before first phase
// R3 - Full level needs all four Hi-Z
// R4 - Otherwise only short tests run
// R5 - Diagnostic start accepted in any state
// R6 - Per-channel short/open results in registers
// R7 - Default phases 20, 20, 100, 230 ms
// R8 - Extend bit makes short phases 80 ms
// R9 - Host extends tests above 680 nF
// R10 - Tweeter status on pin, results by read
// R11 - Faults force Hi-Z at once, no ramp
// R12 - Mute and play ramp gain gradually
// R13 - Per-channel gain select including 12 dB
// R14 - Host tests tweeters one channel at time
// R15 - Pin low while current over threshold
// R16 - Low pulse lasts one switching period minimum
// R17 - Host sets play after tweeter enable
// R18 - Host selects tweeter mode on pin
// R19 - Standby low gives fast pop-free shutdown
// R20 - Tweeter uses averaged current-limit detector
// R21 - Pin sources: clip, warning, both, tweeter
// R22 - Host command clears faults, leaves Hi-Z
// R23 - Full order ground, supply, open, shorted; done
module amp_diag_seq
  import amp_pkg::*;
#(
  parameter int unsigned P_SHORT_CYC = SHORT_CYC,
  parameter int unsigned P_EXT_CYC   = EXT_CYC,
  parameter int unsigned P_OPEN_CYC  = OPEN_CYC,
  parameter int unsigned P_SHLD_CYC  = SHLD_CYC
) (
  input  wire logic       mclk,                  // 20 MHz clock
  input  wire logic       rst_n,                 // Power-on reset
  input  wire logic       reg_wr,                // Register write strobe
  input  wire logic [7:0] reg_addr,              // Register address
  input  wire logic [7:0] reg_wdata,             // Register write data
  output logic      [7:0] reg_rdata_q,           // Read data, one cycle late
  input  wire logic       standby_n_in,          // Standby request
  input  wire amp_flt_s   flt_in,                // Live protection faults
  input  wire amp_det_s   det_in,                // Analog diagnostic comparators
  input  wire logic       thermal_warning,       // Temperature warning level
  input  wire logic [3:0] clip_in,               // Full duty clip per channel
  input  wire logic [3:0] cycle_current_limiter, // Averaged current over threshold
  output logic            clip_warn_out_q,       // Pin drive value, always low
  output logic            clip_warn_oe_n_q,      // Low while pin is pulled low
  output logic      [3:0] hiz_q,                 // Channel Hi-Z, not switching
  output logic      [5:0] ramp_q [4],            // Channel gain ramp level
  output logic      [7:0] gain_sel_q,            // Two gain bits per channel
  output amp_st_e         st_q,                  // Active diagnostic phase
  output logic      [3:0] sel_q                  // Channels under test
);
  logic [7:0]  cwcfg_q;
  logic [7:0]  outctl_q;
  logic [7:0]  diag_q;
  logic [7:0]  res_short_q;
  logic [7:0]  res_load_q;
  logic [3:0]  flt_q;
  logic [3:0]  hold_q;
  logic        done_q;
  logic        full_q;
  logic [22:0] ph_cnt_q;
  logic [11:0] tick_cnt_q;
  logic        tick;
  logic [7:0]  low_cnt_q;
  logic        start;
  logic        clr_flt;
  logic        glob_flt;
  logic [3:0]  live_flt;
  logic [3:0]  run;
  logic [22:0] ph_len;
  logic        ph_end;
  logic        want_low;

  assign start    = reg_wr && (reg_addr == REG_DIAG) && reg_wdata[DC_START];
  assign clr_flt  = reg_wr && (reg_addr == REG_STATUS);
  assign glob_flt = flt_in.overvoltage_fault | flt_in.undervoltage_fault
                    | flt_in.overtemp_fault;
  assign live_flt = {4{glob_flt}} | flt_in.overcurrent_fault | flt_in.dc_offset_fault;
  assign run      = outctl_q[3:0] & ~hold_q & ~flt_q & ~live_flt & {4{standby_n_in}};
  assign tick     = (tick_cnt_q == 12'(RAMP_CYC - 1));

  // Host register writes; start bit is a strobe and is not stored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cwcfg_q    <= RST_CWCFG;
      outctl_q   <= RST_OUTCTL;
      diag_q     <= RST_DIAG;
      gain_sel_q <= RST_GAIN;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_CWCFG:  cwcfg_q    <= reg_wdata;             // [R21]
        REG_OUTCTL: outctl_q   <= reg_wdata;             // [R12]
        REG_GAIN:   gain_sel_q <= reg_wdata;             // [R13]
        REG_DIAG:   diag_q     <= reg_wdata & 8'hDF;     // [R5] [R8]
        default:    ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= 8'h00;
    else
    begin
      case (reg_addr)
        REG_STATUS:    reg_rdata_q <= {hiz_q, |flt_q, full_q, done_q, ~st_q[0]};
        REG_RES_SHORT: reg_rdata_q <= res_short_q;       // [R6]
        REG_RES_LOAD:  reg_rdata_q <= res_load_q;        // [R6]
        REG_GAIN:      reg_rdata_q <= gain_sel_q;
        REG_CWCFG:     reg_rdata_q <= cwcfg_q;
        REG_OUTCTL:    reg_rdata_q <= outctl_q;
        REG_DIAG:      reg_rdata_q <= diag_q;
        default:       reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // A fault arriving with the clear command stays latched
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      flt_q <= 4'h0;
    else
      flt_q <= (clr_flt ? 4'h0 : flt_q) | live_flt;      // [R11] [R22]
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= 12'h000;
    else
      tick_cnt_q <= tick ? 12'h000 : tick_cnt_q + 12'h001;
  end

  // Per-channel ramp: faults cut straight to Hi-Z, standby ramps every cycle
  for (genvar i = 0; i < 4; i++)
  begin : g_ch
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        hiz_q[i]  <= 1'b1;
        ramp_q[i] <= 6'h00;
      end
      else if (flt_q[i] || live_flt[i])
      begin
        hiz_q[i]  <= 1'b1;                               // [R11]
        ramp_q[i] <= 6'h00;
      end
      else if (run[i])
      begin
        hiz_q[i] <= 1'b0;
        if (tick && ramp_q[i] != RAMP_MAX)
          ramp_q[i] <= ramp_q[i] + 6'h01;                // [R12]
      end
      else if (ramp_q[i] == 6'h00)
        hiz_q[i] <= 1'b1;                                // [R1] [R22]
      else if (tick || !standby_n_in)
        ramp_q[i] <= ramp_q[i] - 6'h01;                  // [R12] [R19]
    end
  end

  assign ph_len = (st_q == ST_OL) ? 23'(P_OPEN_CYC) :
                  (st_q == ST_SL) ? 23'(P_SHLD_CYC) :
                  diag_q[DC_EXT] ? 23'(P_EXT_CYC) : 23'(P_SHORT_CYC);  // [R7] [R8]
  assign ph_end = (ph_cnt_q == ph_len - 23'd1);

  // Diagnostic sequencer; a new start restarts from any state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q        <= ST_IDLE;
      sel_q       <= 4'h0;
      hold_q      <= 4'h0;
      done_q      <= 1'b0;
      full_q      <= 1'b0;
      ph_cnt_q    <= 23'd0;
      res_short_q <= 8'h00;
      res_load_q  <= 8'h00;
    end
    else if (start)
    begin
      st_q        <= ST_PREP;                            // [R5]
      sel_q       <= reg_wdata[3:0];
      hold_q      <= reg_wdata[3:0];                     // [R1]
      done_q      <= 1'b0;
      ph_cnt_q    <= 23'd0;
      res_short_q <= 8'h00;
      res_load_q  <= 8'h00;
    end
    else
    begin
      if (clr_flt)
        done_q <= 1'b0;
      case (st_q)
        ST_IDLE: ;
        ST_PREP:
        begin
          // Tested channels must have ramped down and stopped switching
          if ((sel_q & ~hiz_q) == 4'h0)
          begin
            st_q     <= ST_S2G;                          // [R2]
            full_q   <= &hiz_q;                          // [R3] [R4]
            sel_q    <= (&hiz_q) ? 4'hF : sel_q;         // [R3]
            hold_q   <= (&hiz_q) ? 4'hF : hold_q;
            ph_cnt_q <= 23'd0;
          end
        end
        ST_S2G, ST_S2P, ST_OL, ST_SL:
        begin
          ph_cnt_q <= ph_end ? 23'd0 : ph_cnt_q + 23'd1;
          if (ph_end)
          begin
            case (st_q)
              ST_S2G:
              begin
                res_short_q[3:0] <= res_short_q[3:0] | (det_in.short_to_ground_test & sel_q);
                st_q <= ST_S2P;                          // [R23]
              end
              ST_S2P:
              begin
                res_short_q[7:4] <= res_short_q[7:4] | (det_in.short_to_supply_test & sel_q);
                st_q <= full_q ? ST_OL : ST_IDLE;        // [R3] [R4]
              end
              ST_OL:
              begin
                res_load_q[3:0] <= res_load_q[3:0] | (det_in.open_load_test & sel_q);
                st_q <= ST_SL;                           // [R23]
              end
              default:
              begin
                res_load_q[7:4] <= res_load_q[7:4] | (det_in.shorted_load_test & sel_q);
                st_q <= ST_IDLE;
              end
            endcase
            if (st_q == ST_SL || (st_q == ST_S2P && !full_q))
            begin
              done_q <= 1'b1;                            // [R23]
              hold_q <= 4'h0;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Pin source select; tweeter mode also needs the tweeter enable bit
  always_comb
  begin
    case (cwcfg_q[1:0])
      CW_CLIP:  want_low = |clip_in;
      CW_WARN:  want_low = thermal_warning;
      CW_BOTH:  want_low = (|clip_in) | thermal_warning;  // [R21]
      default:  want_low = diag_q[DC_TWEET] & |(cycle_current_limiter & ~hiz_q); // [R15] [R20]
    endcase
  end

  // A low pulse is held for at least one switching period
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clip_warn_oe_n_q <= 1'b1;
      clip_warn_out_q  <= 1'b0;
      low_cnt_q        <= 8'h00;
    end
    else
    begin
      clip_warn_out_q  <= 1'b0;
      clip_warn_oe_n_q <= ~(want_low || (!clip_warn_oe_n_q
                            && low_cnt_q < 8'(SW_CYC - 1)));  // [R10] [R15] [R16]
      if (clip_warn_oe_n_q)
        low_cnt_q <= 8'h00;
      else if (low_cnt_q != 8'hFF)
        low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  localparam int STBY_WAIT = 66;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_s2g_to_s2p;
    (st_q == ST_S2G) ##1 (st_q == ST_S2P);
  endsequence
  sequence s_prep_to_s2g;
    (st_q == ST_PREP) ##1 (st_q == ST_S2G);
  endsequence

  property p_diag_hiz;
    !(st_q inside {ST_IDLE, ST_PREP}) |-> ((sel_q & ~hiz_q) == 4'h0);
  endproperty
  a_diag_hiz: assert property (p_diag_hiz)  // [R1]
    else $error("tested channel not in Hi-Z during a phase");

  property p_pop_free;
    s_prep_to_s2g |-> (((ramp_q[0] & {6{sel_q[0]}}) | (ramp_q[1] & {6{sel_q[1]}})
                       | (ramp_q[2] & {6{sel_q[2]}}) | (ramp_q[3] & {6{sel_q[3]}})) == 6'h00);
  endproperty
  a_pop_free: assert property (p_pop_free)  // [R2]
    else $error("phase began before ramp finished");

  property p_full_level;
    s_prep_to_s2g |-> (full_q == (&$past(hiz_q)));
  endproperty
  a_full_level: assert property (p_full_level)  // [R3]
    else $error("full level choice does not match Hi-Z state");

  property p_reduced;
    (st_q == ST_S2P && ph_end && !full_q && !start) |=> (st_q == ST_IDLE) && done_q;
  endproperty
  a_reduced: assert property (p_reduced)  // [R4]
    else $error("reduced level ran beyond short tests");

  property p_start_any;
    start |=> (st_q == ST_PREP) && !done_q;
  endproperty
  a_start_any: assert property (p_start_any)  // [R5]
    else $error("diagnostic start not accepted");

  property p_result;
    (st_q == ST_S2G && ph_end && !start) |=>
      res_short_q[3:0] == ($past(res_short_q[3:0])
                           | ($past(det_in.short_to_ground_test) & sel_q));
  endproperty
  a_result: assert property (p_result)  // [R6]
    else $error("short-to-ground result not recorded");

  property p_phase_len;
    s_s2g_to_s2p |-> $past(ph_cnt_q) == ($past(diag_q[DC_EXT]) ?
                       23'(P_EXT_CYC - 1) : 23'(P_SHORT_CYC - 1));
  endproperty
  a_phase_len: assert property (p_phase_len)  // [R7] [R8]
    else $error("short phase length wrong");

  property p_fault_hiz;
    live_flt[0] |=> hiz_q[0] && (ramp_q[0] == 6'h00);
  endproperty
  a_fault_hiz: assert property (p_fault_hiz)  // [R11]
    else $error("fault did not force Hi-Z at once");

  property p_tweet_low;
    (cwcfg_q[1:0] == CW_TWEET && want_low) |=> !clip_warn_oe_n_q;
  endproperty
  a_tweet_low: assert property (p_tweet_low)  // [R15]
    else $error("pin not pulled low on tweeter detect");

  property p_min_pulse;
    $rose(clip_warn_oe_n_q) |-> $past(low_cnt_q) >= 8'(SW_CYC - 1);
  endproperty
  a_min_pulse: assert property (p_min_pulse)  // [R16]
    else $error("low pulse shorter than switching period");

  property p_standby;
    (!standby_n_in && !hiz_q[0]) [*1] ##1 !standby_n_in |-> ##[0:STBY_WAIT] hiz_q[0];
  endproperty
  a_standby: assert property (p_standby)  // [R19]
    else $error("standby shutdown too slow");
endmodule // amp_diag_seq

// *** include/amp_pkg.sv ***
// Shared constants, register map and types for the amplifier diagnostic sequencer
package amp_pkg;
  localparam int unsigned CLK_KHZ      = 20_000;
  // Diagnostic phase times in ms
  localparam int unsigned T_SHORT_MS   = 20;
  localparam int unsigned T_EXT_MS     = 80;
  localparam int unsigned T_OPEN_MS    = 100;
  localparam int unsigned T_SHLD_MS    = 230;
  localparam int unsigned SHORT_CYC    = T_SHORT_MS * CLK_KHZ;
  localparam int unsigned EXT_CYC      = T_EXT_MS * CLK_KHZ;
  localparam int unsigned OPEN_CYC     = T_OPEN_MS * CLK_KHZ;
  localparam int unsigned SHLD_CYC     = T_SHLD_MS * CLK_KHZ;
  // Switching period, least low time of a tweeter pulse, rounded up
  localparam int unsigned SW_PERIOD_NS = 2500;
  localparam int unsigned SW_CYC       = (SW_PERIOD_NS * CLK_KHZ + 999_999) / 1_000_000;
  // Gain ramp step time in us
  localparam int unsigned RAMP_STEP_US = 100;
  localparam int unsigned RAMP_CYC     = RAMP_STEP_US * CLK_KHZ / 1000;
  localparam logic [5:0]  RAMP_MAX     = 6'h3F;

  localparam logic [7:0] REG_STATUS    = 8'h01;
  localparam logic [7:0] REG_RES_SHORT = 8'h02;
  localparam logic [7:0] REG_RES_LOAD  = 8'h03;
  localparam logic [7:0] REG_GAIN      = 8'h05;
  localparam logic [7:0] REG_CWCFG     = 8'h0A;
  localparam logic [7:0] REG_OUTCTL    = 8'h0C;
  localparam logic [7:0] REG_DIAG      = 8'h10;

  localparam logic [7:0] RST_CWCFG     = 8'h01;
  localparam logic [7:0] RST_OUTCTL    = 8'h00;
  localparam logic [7:0] RST_DIAG      = 8'h00;
  localparam logic [7:0] RST_GAIN      = 8'h00;

  localparam int unsigned DC_EXT       = 4;
  localparam int unsigned DC_START     = 5;
  localparam int unsigned DC_TWEET     = 6;

  localparam logic [1:0] CW_CLIP       = 2'h0;
  localparam logic [1:0] CW_WARN       = 2'h1;
  localparam logic [1:0] CW_BOTH       = 2'h2;
  localparam logic [1:0] CW_TWEET      = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PREP = 6'h02,
    ST_S2G  = 6'h04,
    ST_S2P  = 6'h08,
    ST_OL   = 6'h10,
    ST_SL   = 6'h20
  } amp_st_e;

  typedef struct packed {
    logic       overvoltage_fault;
    logic       undervoltage_fault;
    logic       overtemp_fault;
    logic [3:0] overcurrent_fault;
    logic [3:0] dc_offset_fault;
  } amp_flt_s;

  typedef struct packed {
    logic [3:0] short_to_ground_test;
    logic [3:0] short_to_supply_test;
    logic [3:0] open_load_test;
    logic [3:0] shorted_load_test;
  } amp_det_s;
endpackage

// *** testbench/amp_diag_seq_tb_top.sv ***
// Self-checking bench for the load diagnostic sequencer
module amp_diag_seq_tb_top
  import amp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T_S = 20;
  localparam int T_E = 80;
  localparam int T_O = 100;
  localparam int T_L = 230;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       standby_n_in = 1'b1;
  amp_flt_s   flt_in = '0;
  amp_det_s   pat = '0;
  logic       thermal_warning = 1'b0;
  logic [3:0] clip_in = 4'h0;
  logic [3:0] twt = 4'h0;
  logic [7:0] reg_rdata_q, gain_sel_q, rd, g;
  amp_det_s   det_in;
  logic [3:0] cycle_current_limiter, hiz_q, sel_q;
  logic       clip_warn_out_q, clip_warn_oe_n_q, pin;
  logic [5:0] ramp_q [4];
  amp_st_e    st_q;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         n, len;
  logic [7:0] ra [6] = '{REG_CWCFG, REG_OUTCTL, REG_DIAG, REG_GAIN, 8'h7E, REG_RES_SHORT};
  logic [7:0] rv [6] = '{RST_CWCFG, RST_OUTCTL, RST_DIAG, RST_GAIN, 8'h00, 8'h00};
  logic [10:0] fv [5] = '{11'h400, 11'h200, 11'h100, 11'h010, 11'h001};
  int         tl [3] = '{3, 80, 40};

  always #25 mclk = ~mclk;

  amp_diag_seq #(.P_SHORT_CYC(T_S), .P_EXT_CYC(T_E), .P_OPEN_CYC(T_O), .P_SHLD_CYC(T_L))
    amp_diag_seq_inst (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .standby_n_in(standby_n_in),
    .flt_in(flt_in), .det_in(det_in), .thermal_warning(thermal_warning), .clip_in(clip_in),
    .cycle_current_limiter(cycle_current_limiter), .clip_warn_out_q(clip_warn_out_q),
    .clip_warn_oe_n_q(clip_warn_oe_n_q), .hiz_q(hiz_q), .ramp_q(ramp_q),
    .gain_sel_q(gain_sel_q), .st_q(st_q), .sel_q(sel_q));
  amp_load_model amp_load_model_inst (.mclk(mclk), .pat(pat), .twt(twt), .hiz(hiz_q),
    .st(st_q), .out(clip_warn_out_q), .oe_n(clip_warn_oe_n_q), .det(det_in),
    .ccl(cycle_current_limiter), .pin(pin));

  task automatic stop_test();
    $display("samples_checked=%0d n_fail=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      n_fail++;
      $display("ERROR t=%0t count got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    tick();
    reg_addr = a;
    tick();
    rd = reg_rdata_q;
  endtask
  // Waits for a phase, then times it; tested channels must be quiet throughout
  task automatic phase(input amp_st_e s, input int exp, input amp_st_e nx);
    int k;
    logic [3:0] rz;
    k = 0;
    while (st_q !== s && k < 9000)
    begin
      tick();
      k++;
    end
    n = 0;
    while (st_q === s && n < 9000)
    begin
      for (int i = 0; i < 4; i++)
        rz[i] = (ramp_q[i] == 6'h00);
      chk({4'h0, sel_q & ~(hiz_q & rz)}, 8'h00);
      tick();
      n++;
    end
    chk_n(n, exp);
    chk({2'b00, st_q}, {2'b00, nx});
  endtask
  task automatic run_diag(input logic [7:0] ctl, input logic full);
    int ts;
    ts = ctl[4] ? T_E : T_S;
    pat = 16'($urandom) & (full ? 16'hFFFF : {4{ctl[3:0]}});
    wr(REG_DIAG, ctl);
    phase(ST_S2G, ts, ST_S2P);
    phase(ST_S2P, ts, full ? ST_OL : ST_IDLE);
    if (full)
    begin
      phase(ST_OL, T_O, ST_SL);
      phase(ST_SL, T_L, ST_IDLE);
    end
    rdreg(REG_RES_SHORT);
    chk(rd, {pat.short_to_supply_test, pat.short_to_ground_test});
    rdreg(REG_RES_LOAD);
    chk(rd, full ? {pat.shorted_load_test, pat.open_load_test} : 8'h00);
    rdreg(REG_STATUS);
    chk({5'h00, rd[2:0]}, {5'h00, full, 2'b10});
  endtask
  function automatic logic want(input int m, input int s);
    return s ? (m != 0) : (m != 1);
  endfunction

  initial
  begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    void'($urandom(32'h6c52_fec4));
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk({3'h0, clip_warn_oe_n_q, hiz_q}, 8'h1F);
    wr(REG_RES_SHORT, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      rdreg(ra[i]);
      chk(rd, rv[i]);
    end
    // Channel 0 forced to the line-level setting
    g = 8'($urandom) & 8'hFC;
    wr(REG_GAIN, g);
    tick();
    chk(gain_sel_q, g);
    wr(REG_OUTCTL, 8'h01);
    tick();
    chk({7'h0, hiz_q[0]}, 8'h00);
    tick(4500);
    chk({7'h0, ramp_q[0] inside {[6'h01:6'h03]}}, 8'h01);
    run_diag(8'h21, 1'b1);
    run_diag(8'h3F, 1'b1);
    tick(4);
    run_diag(8'h22, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      tick(3);
      chk({7'h0, hiz_q[0]}, 8'h00);
      flt_in = fv[k];
      tick();
      chk({6'h0, hiz_q[0], ramp_q[0] == 6'h00}, 8'h03);
      flt_in = '0;
      tick(2);
      chk({7'h0, hiz_q[0]}, 8'h01);
      rdreg(REG_STATUS);
      chk({rd[7:3], 3'h0}, 8'hF8);
      wr(REG_STATUS, 8'h00);
      rdreg(REG_STATUS);
      chk({4'h0, rd[3], 3'h0}, 8'h00);
    end
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 2; s++)
      begin
        wr(REG_CWCFG, 8'(m));
        clip_in = s ? 4'h0 : 4'h4;
        thermal_warning = s[0];
        tick(2);
        chk({6'h0, clip_warn_out_q, pin}, {7'h0, ~want(m, s)});
        clip_in = 4'h0;
        thermal_warning = 1'b0;
        tick(60);
      end
    wr(REG_CWCFG, 8'h03);
    wr(REG_DIAG, 8'h40);
    wr(REG_OUTCTL, 8'h02);
    tick(3);
    for (int j = 0; j < 4; j++)
    begin
      len = (j == 3) ? 1 + $urandom_range(119) : tl[j];
      twt = (j == 2) ? 4'h8 : 4'h2;
      n = 0;
      for (int c = 0; c < 200; c++)
      begin
        if (c == len)
          twt = 4'h0;
        tick();
        n += (pin === 1'b0);
      end
      chk_n(n, (j == 2) ? 0 : (len < 50 ? 50 : len));
    end
    wr(REG_OUTCTL, 8'h0F);
    tick(2);
    chk({4'h0, hiz_q}, 8'h00);
    standby_n_in = 1'b0;
    tick(70);
    chk({4'h0, hiz_q}, 8'h0F);
    stop_test();
  end
endmodule // amp_diag_seq_tb_top

// *** testbench/amp_load_model.sv ***
// Speaker load, diagnostic comparator and pull-up model facing the sequencer
module amp_load_model
  import amp_pkg::*;
(
  input  wire logic       mclk, // Clock, kept for timing reference
  input  wire amp_det_s   pat,  // Load faults present on each channel
  input  wire logic [3:0] twt,  // Tweeter present and test tone applied
  input  wire logic [3:0] hiz,  // Channel not switching
  input  wire amp_st_e    st,   // Active diagnostic phase
  input  wire logic       out,  // Pin drive value
  input  wire logic       oe_n, // Pin pull-down off
  output amp_det_s        det,  // Comparator outputs
  output logic      [3:0] ccl,  // Averaged current over threshold
  output logic            pin   // Pin level seen by the host
);
  timeunit 1ns;
  timeprecision 100ps;
  // An idle comparator reads garbage, so it shows the inverse of the real load
  always_comb
  begin
    det = ~pat;
    case (st)
      ST_S2G:  det.short_to_ground_test = pat.short_to_ground_test;
      ST_S2P:  det.short_to_supply_test = pat.short_to_supply_test;
      ST_OL:   det.open_load_test = pat.open_load_test;
      ST_SL:   det.shorted_load_test = pat.shorted_load_test;
      default: ;
    endcase
  end
  // No current flows into a load whose bridge is not switching
  assign ccl = twt & ~hiz;
  // Open drain with pull-up: released line reads high
  assign pin = oe_n ? 1'b1 : out;
endmodule // amp_load_model
